// [core/tpg_lfsr.sv]
// Reference distortion scrambler of period 2047, advanced one bit per enable.
// Assumes the owner holds restart outside the distortion mode.
`timescale 1ns/1ps
module tpg_lfsr
    import tpg_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Control
    input wire logic restart,
    input wire logic step,
    // State
    output logic [TPG_SCR_LEN-1:0] state
);

    logic new_bit;

    assign new_bit = state[TPG_SCR_TAP_A] ^ state[TPG_SCR_TAP_B];

    always_ff @(posedge clk) begin
        if (sys_rst || restart) begin
            state <= TPG_SCR_SEED;
        end else if (step) begin
            state <= {state[TPG_SCR_LEN-2:0], new_bit};
        end
    end

endmodule : tpg_lfsr

// [core/tpg_pkg.sv]
// Package for the transmit test-pattern generator: modes, symbol coding, timing counts.
// Assumes one symbol clock shared by the normal transmit path and this block.
package tpg_pkg;

    // Test-mode setting codes
    typedef enum logic [2:0] {
        TPG_MODE_NORMAL = 3'h0,
        TPG_MODE_DROOP = 3'h1,
        TPG_MODE_MJIT = 3'h2,
        TPG_MODE_SJIT = 3'h3,
        TPG_MODE_DIST = 3'h4,
        TPG_MODE_PSD = 3'h5
    } tpg_mode_t;

    localparam logic [2:0] TPG_MODE_RST = 3'h0;

    // Ternary symbol in two's complement: +1, 0, -1
    localparam logic [1:0] TPG_SYM_POS = 2'h1;
    localparam logic [1:0] TPG_SYM_ZERO = 2'h0;
    localparam logic [1:0] TPG_SYM_NEG = 2'h3;

    // Symbol clock period in ps (66 2/3 MHz)
    localparam int TPG_SYM_PERIOD_PS = 15000;
    // Least droop run time in ns, and run length rounded up to symbols plus one
    localparam int TPG_DROOP_MIN_NS = 500;
    localparam int TPG_DROOP_RUN =
        (TPG_DROOP_MIN_NS * 1000 + TPG_SYM_PERIOD_PS - 1) / TPG_SYM_PERIOD_PS + 1;

    // Distortion scrambler: 11 stages, taps 11 and 9, seed all ones
    localparam int TPG_SCR_LEN = 11;
    localparam logic [10:0] TPG_SCR_SEED = 11'h7FF;
    localparam int TPG_SCR_TAP_A = 10;
    localparam int TPG_SCR_TAP_B = 8;

    // Symbol with its valid strobe
    typedef struct packed {
        logic valid;
        logic [1:0] sym;
    } tpg_sym_t;

endpackage : tpg_pkg

// [core/tpg_top.sv]
// Transmit test-pattern selector: replaces normal ternary symbols with test patterns.
// Assumes clk is the transmit symbol clock (recovered clock in slave timing) and that
// the management setting and normal symbols come from logic on the same clock.
`timescale 1ns/1ps
// Function
// - A 3-bit setting selects normal, droop, master jitter, slave jitter, distortion or PSD.
// - Codes 110 and 111 are reserved and management must not program them.
// - Test modes change only the data symbols, never symbol timing or other behaviour; PSD mode also forces full_power high.
// - Droop mode sends N plus-one symbols then N minus-one symbols.
// - N symbol periods last longer than 500 ns.
// - Master jitter mode sends alternating plus-one and minus-one on the local clock.
// - Slave jitter mode, implemented here, sends the alternating pattern repeatedly.
// - Slave jitter symbols are timed from the slave-timing symbol clock.
// - Distortion mode emits one symbol every 15 ns from the symbol clock.
// - Distortion bit pairs map 00 to 0, 01 to +1, 10 to 0 and 11 to -1.
// - PSD mode sends the normal side-stream scrambled symbol stream at full power.
// - The symbol clock that times transmitted symbols is brought out.
// - A control enables the symbol-clock output, which is off by default.
// - The distortion pattern comes from an 11-stage all-ones-seeded scrambler, taps 11 and 9.
module tpg_top
    import tpg_pkg::*;
#(
    parameter int DROOP_RUN = TPG_DROOP_RUN
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Management
    input wire logic [2:0] test_mode_set,
    input wire logic test_mode_wr,
    input wire logic tx_clk_out_en,
    // Normal transmit path
    input wire tpg_sym_t normal_sym,
    input wire logic full_power_in,
    // To transmitter front end
    output tpg_sym_t tx_sym,
    output logic full_power,
    output logic tx_symbol_clock_out_en,
    // Status
    output logic [2:0] test_mode_rd
);

    localparam int RUN_W = $clog2(DROOP_RUN + 1);

    logic [2:0] mode_reg;
    logic [RUN_W-1:0] run_cnt_reg;
    logic droop_neg_reg;
    logic alt_reg;
    logic [TPG_SCR_LEN-1:0] scr_state;
    logic mode_change;
    logic pattern_high_bit;
    logic pattern_low_bit;
    tpg_sym_t sym_next;

    // Map a distortion bit pair to a ternary symbol
    function automatic logic [1:0] dist_map(input logic hi, input logic lo);
        case ({hi, lo})
            2'h1: dist_map = TPG_SYM_POS;
            2'h3: dist_map = TPG_SYM_NEG;
            default: dist_map = TPG_SYM_ZERO;
        endcase
    endfunction : dist_map

    assign mode_change = test_mode_wr && (test_mode_set != mode_reg);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mode_reg <= TPG_MODE_RST;
        end else if (test_mode_wr) begin
            mode_reg <= test_mode_set;
        end
    end

    // Droop run counter, restarted on any mode change
    always_ff @(posedge clk) begin
        if (sys_rst || mode_change || mode_reg != TPG_MODE_DROOP) begin
            run_cnt_reg <= '0;
            droop_neg_reg <= 1'b0;
        end else if (run_cnt_reg == RUN_W'(DROOP_RUN - 1)) begin
            run_cnt_reg <= '0;
            droop_neg_reg <= ~droop_neg_reg;
        end else begin
            run_cnt_reg <= run_cnt_reg + RUN_W'(1);
        end
    end

    // Alternating phase for both jitter modes
    always_ff @(posedge clk) begin
        if (sys_rst || mode_change) begin
            alt_reg <= 1'b0;
        end else begin
            alt_reg <= ~alt_reg;
        end
    end

    tpg_lfsr u_lfsr (
        .clk(clk),
        .sys_rst(sys_rst),
        .restart(mode_change || mode_reg != TPG_MODE_DIST),
        .step(1'b1),
        .state(scr_state)
    );

    // Pair the current bit with the bits 1 and 4 back, as the reference pattern does
    assign pattern_low_bit = scr_state[0];
    assign pattern_high_bit = scr_state[0] & (scr_state[1] ^ scr_state[4]);

    always_comb begin
        sym_next = normal_sym;
        case (mode_reg)
            TPG_MODE_DROOP: begin
                sym_next.valid = 1'b1;
                sym_next.sym = droop_neg_reg ? TPG_SYM_NEG : TPG_SYM_POS;
            end
            TPG_MODE_MJIT, TPG_MODE_SJIT: begin
                sym_next.valid = 1'b1;
                sym_next.sym = alt_reg ? TPG_SYM_NEG : TPG_SYM_POS;
            end
            TPG_MODE_DIST: begin
                sym_next.valid = 1'b1;
                sym_next.sym = dist_map(pattern_high_bit, pattern_low_bit);
            end
            TPG_MODE_PSD: sym_next = normal_sym;
            default: sym_next = normal_sym;
        endcase
    end

    // Symbols go out one per clock, same pipeline depth in every mode
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tx_sym <= '0;
            full_power <= 1'b0;
        end else begin
            tx_sym <= sym_next;
            full_power <= full_power_in || (mode_reg == TPG_MODE_PSD);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tx_symbol_clock_out_en <= 1'b0;
        end else begin
            tx_symbol_clock_out_en <= tx_clk_out_en;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            test_mode_rd <= TPG_MODE_RST;
        end else begin
            test_mode_rd <= test_mode_wr ? test_mode_set : mode_reg;
        end
    end

endmodule : tpg_top

// [sim/tb_top.sv]
// Bench for the test-pattern selector.
// Assumes checker and model compiled first.
`timescale 1ns/1ps
module tb_top;
    import tpg_pkg::*;
    localparam int DROOP_RUN = 4;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [2:0] test_mode_set = 3'h0;
    logic test_mode_wr = 1'b0;
    logic tx_clk_out_en = 1'b0;
    tpg_sym_t normal_sym = 3'h0;
    logic full_power_in = 1'b0;
    tpg_sym_t tx_sym;
    logic full_power;
    logic tx_symbol_clock_out_en;
    logic [2:0] test_mode_rd;
    int pulse_cnt;
    int err_total = 0;
    int tests_run = 0;
    tpg_top #(.DROOP_RUN(DROOP_RUN)) i_dut (.*);
    tpg_fe_model i_fe (.clk, .clk_en(tx_symbol_clock_out_en), .pulse_cnt);
    always #4 clk = ~clk;
    task step;
        @(posedge clk);
        #1;
    endtask : step
    task chk(input logic [2:0] got, input logic [2:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task wr(input logic [2:0] m);
        @(posedge clk) test_mode_set <= m;
        test_mode_wr <= 1'b1;
        @(posedge clk) test_mode_wr <= 1'b0;
        #1;
        chk(test_mode_rd, m);
    endtask : wr
    task t_rst;
        @(posedge clk) sys_rst <= 1'b1;
        repeat (16) step;
        @(posedge clk) sys_rst <= 1'b0;
        #1;
        chk(tx_sym, 3'h0);
        chk(test_mode_rd, TPG_MODE_RST);
        $display("t_rst done");
    endtask : t_rst
    task t_pass(input logic [2:0] m);
        wr(m);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk) normal_sym <= {1'b1, 2'(i)};
            full_power_in <= i[0];
            step;
            chk(tx_sym, {1'b1, 2'(i)});
            chk({2'h0, full_power}, {2'h0, m == 3'h5 || i[0]});
        end
        @(posedge clk) full_power_in <= 1'b0;
        $display("t_pass done");
    endtask : t_pass
    task t_run(input logic [2:0] m, input int n);
        wr(m);
        chk({2'h0, TPG_DROOP_RUN * 15 > 500}, 3'h1);
        for (int k = 0; k < 4 * n; k++) begin
            step;
            chk({1'b0, tx_sym.sym}, {1'b0, (k / n) % 2 ? TPG_SYM_NEG : TPG_SYM_POS});
        end
        $display("t_run done");
    endtask : t_run
    task t_dist;
        logic [10:0] s;
        logic [1:0] b;
        s = 11'h7FF;
        wr(TPG_MODE_DIST);
        for (int k = 0; k < 64; k++) begin
            step;
            b = {s[0] & (s[1] ^ s[4]), s[0]};
            chk(tx_sym, {1'b1, b == 2'h1 ? TPG_SYM_POS : b == 2'h3 ? TPG_SYM_NEG : 2'h0});
            s = {s[9:0], s[10] ^ s[8]};
        end
        $display("t_dist done");
    endtask : t_dist
    task t_clk;
        int n0;
        @(posedge clk) tx_clk_out_en <= 1'b1;
        #1;
        n0 = pulse_cnt;
        repeat (6) step;
        chk(3'(pulse_cnt - n0), 3'h5);
        @(posedge clk) tx_clk_out_en <= 1'b0;
        repeat (4) step;
        chk(3'(pulse_cnt - n0), 3'h7);
        $display("t_clk done");
    endtask : t_clk
    task complete_run;
        $display("checks %0d errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run
    initial begin
        t_rst;
        t_pass(TPG_MODE_NORMAL);
        t_pass(TPG_MODE_PSD);
        t_pass(3'h6);
        t_pass(3'h7);
        t_run(TPG_MODE_DROOP, DROOP_RUN);
        t_run(TPG_MODE_MJIT, 1);
        t_run(TPG_MODE_SJIT, 1);
        t_dist;
        t_rst;
        t_clk;
        complete_run;
    end
    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        complete_run;
    end
endmodule : tb_top
bind tpg_top tpg_assertions #(.DROOP_RUN(DROOP_RUN)) i_chk (.*);

// [sim/tpg_assertions.sv]
// Port checker for the transmit test-pattern selector.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module tpg_assertions
    import tpg_pkg::*;
#(
    parameter int DROOP_RUN = 4
) (
    // Inputs
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [2:0] test_mode_set,
    input wire logic test_mode_wr,
    input wire logic tx_clk_out_en,
    input wire tpg_sym_t normal_sym,
    input wire logic full_power_in,
    // Outputs
    input wire tpg_sym_t tx_sym,
    input wire logic full_power,
    input wire logic tx_symbol_clock_out_en,
    input wire logic [2:0] test_mode_rd
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_droop;
        tx_sym.sym == TPG_SYM_POS ##DROOP_RUN tx_sym.sym == TPG_SYM_NEG
            ##DROOP_RUN tx_sym.sym == TPG_SYM_POS;
    endsequence
    property p_rd;
        test_mode_wr |=> test_mode_rd == $past(test_mode_set);
    endproperty
    property p_rst;
        $fell(sys_rst) |-> test_mode_rd == TPG_MODE_RST && tx_sym == 3'h0;
    endproperty
    property p_pass;
        (test_mode_rd == 3'h0 || test_mode_rd[2:1] == 2'h3) |=> tx_sym == $past(normal_sym);
    endproperty
    property p_psd;
        test_mode_rd == 3'h5 |=> full_power && tx_sym == $past(normal_sym);
    endproperty
    property p_clk;
        1'b1 |=> tx_symbol_clock_out_en == $past(tx_clk_out_en);
    endproperty
    property p_alt;
        test_mode_rd[2:1] == 2'h1 && $stable(test_mode_rd)
            |=> tx_sym.sym[0] && tx_sym.sym != $past(tx_sym.sym);
    endproperty
    property p_droop;
        $rose(test_mode_rd == 3'h1) |=> s_droop;
    endproperty
    property p_dist;
        test_mode_rd == 3'h4 |=> tx_sym.valid && tx_sym.sym != 2'h2;
    endproperty
    a_rd: assert property (p_rd) else $error("bad readback");
    a_rst: assert property (p_rst) else $error("bad reset");
    a_pass: assert property (p_pass) else $error("bad pass");
    a_psd: assert property (p_psd) else $error("bad psd");
    a_clk: assert property (p_clk) else $error("bad clk en");
    a_alt: assert property (p_alt) else $error("bad jitter");
    a_droop: assert property (p_droop) else $error("bad droop");
    a_dist: assert property (p_dist) else $error("bad dist");
endmodule : tpg_assertions

// [sim/tpg_fe_model.sv]
// Front end and test gear: counts pad clock pulses.
// Assumes the pad clock stands still while disabled.
`timescale 1ns/1ps
module tpg_fe_model (
    // Clock and pad enable
    input wire logic clk,
    input wire logic clk_en,
    // Pulse count
    output int pulse_cnt = 0
);
    always @(posedge clk) begin
        if (clk_en) begin
            pulse_cnt <= pulse_cnt + 1;
        end
    end
endmodule : tpg_fe_model
